/* File: mac_side_model.sv */
// partner: mac side that finishes a transmit some cycles after a request
`timescale 1ns/1ps
module mac_side_model #(
   parameter int DELAY = 6
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire net_regs_pkg::mac_control_t mac_control,
   output logic                            tx_complete
);
   import net_regs_pkg::*;
   int cnt;
   // one pulse per request: cnt runs past DELAY until the request drops
   always_ff @(posedge core_clk) begin
      if (rst || !mac_control.transmit_request) begin
         cnt         <= 0;
         tx_complete <= 1'b0;
      end else begin
         cnt         <= cnt + 1;
         tx_complete <= (cnt == DELAY);
      end
   end
endmodule

/* File: net_regs_pkg.sv */
// package: offsets, field positions, reset values and timing for the network register bank
package net_regs_pkg;

   localparam int          ADDR_W             = 8;
   localparam int          DATA_W             = 8;

   localparam logic [7:0]  OFF_NETWORK_CONTROL  = 8'h00;
   localparam logic [7:0]  OFF_NETWORK_STATUS   = 8'h01;
   localparam logic [7:0]  OFF_TRANSMIT_CONTROL = 8'h02;

   // network_control fields
   localparam int          NC_WAKE_EN         = 6;
   localparam int          NC_FORCE_COL       = 4;
   localparam int          NC_DUPLEX          = 3;
   localparam int          NC_LOOP_HI         = 2;
   localparam int          NC_LOOP_LO         = 1;
   localparam int          NC_SOFT_RESET      = 0;

   // network_status fields
   localparam int          NS_SPEED           = 7;
   localparam int          NS_LINK            = 6;
   localparam int          NS_WAKE_EVENT      = 5;
   localparam int          NS_TWO_DONE        = 3;
   localparam int          NS_ONE_DONE        = 2;
   localparam int          NS_RX_OVERFLOW     = 1;

   // transmit_control fields
   localparam int          TC_JABBER_OFF      = 6;
   localparam int          TC_EXCESS_RETRY    = 5;
   localparam int          TC_TWO_PAD_OFF     = 4;
   localparam int          TC_TWO_FCS_OFF     = 3;
   localparam int          TC_ONE_PAD_OFF     = 2;
   localparam int          TC_ONE_FCS_OFF     = 1;
   localparam int          TC_TX_REQUEST      = 0;

   localparam logic [1:0]  LOOPBACK_RESET     = 2'h0;
   localparam logic        BIT_RESET          = 1'b0;
   localparam logic [7:0]  RESERVED_READ      = 8'h00;

   localparam int          COLLISION_LIMIT    = 15;
   localparam int          JABBER_BYTES       = 2048;

   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          SOFT_RESET_US      = 10;
   localparam int          SOFT_RESET_CYCLES  = (SOFT_RESET_US * 1000) / CLK_PERIOD_NS;
   localparam int          SOFT_CNT_W         = 11;

   typedef enum logic [1:0] {
      LOOP_NORMAL   = 2'h0,
      LOOP_MAC      = 2'h1,
      LOOP_PHY_100M = 2'h2,
      LOOP_RESERVED = 2'h3
   } loopback_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic phy_speed_10;
      logic phy_link_good;
      logic phy_duplex_flag;
      logic receive_fifo_overflow;
      logic wakeup_event;
      logic index_one_tx_done;
      logic index_two_tx_done;
      logic tx_busy_one;
      logic tx_busy_two;
   } mac_status_t;

   typedef struct packed {
      logic      wakeup_function_enable;
      logic      forced_collision_test;
      loopback_t loopback_select;
      logic      soft_reset_active;
      logic      jabber_timer_disable;
      logic      excess_collision_retry;
      logic      index_two_pad_off;
      logic      index_two_fcs_off;
      logic      index_one_pad_off;
      logic      index_one_fcs_off;
      logic      transmit_request;
   } mac_control_t;

endpackage

/* File: net_regs_props.sv */
// checker: port timing relations of the network register bank
`timescale 1ns/1ps
module net_regs_props #(
   parameter int SOFT_RESET_LEN = 8
) (
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire net_regs_pkg::reg_req_t     bus_req,
   input wire logic [net_regs_pkg::DATA_W-1:0] rdata,
   input wire net_regs_pkg::mac_status_t  mac_status,
   input wire logic                       tx_complete,
   input wire net_regs_pkg::mac_control_t mac_control
);
   import net_regs_pkg::*;
   // idle uses the lagged output, so writes near a soft reset edge are left out
   wire logic idle  = !mac_control.soft_reset_active;
   wire logic rd_st = bus_req.rd && bus_req.addr == OFF_NETWORK_STATUS;
   wire logic rd_nc = bus_req.rd && bus_req.addr == OFF_NETWORK_CONTROL;
   wire logic rd_tc = bus_req.rd && bus_req.addr == OFF_TRANSMIT_CONTROL;
   wire logic wr_nc = bus_req.wr && bus_req.addr == OFF_NETWORK_CONTROL && idle;
   wire logic wr_tx = bus_req.wr && bus_req.addr == OFF_TRANSMIT_CONTROL && idle
                      && bus_req.wdata[0];
   wire logic no_ev = mac_status[4:2] == 3'h0;
   int        soft_cnt;
   always_ff @(posedge core_clk) begin
      if (rst || idle)
         soft_cnt <= 0;
      else
         soft_cnt <= soft_cnt + 1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   sequence s_rd_quiet;
      rd_st && no_ev;
   endsequence
   // read-back and control outputs come from one register, so they agree at one edge
   property p_nc_read;
      $past(rd_nc) |-> !rdata[7] && !rdata[5] && rdata[3] == $past(mac_status[6])
         && {rdata[6], rdata[4], rdata[2:0]} == mac_control[11:7];
   endproperty
   property p_ns_read;
      $past(rd_st) |-> rdata[7:6] == $past(mac_status[8:7]) && rdata[1] == $past(mac_status[5])
         && !rdata[4] && !rdata[0];
   endproperty
   property p_read_clears;
      s_rd_quiet ##1 no_ev ##1 s_rd_quiet |=> rdata[5] == 1'b0 && rdata[3:2] == 2'h0;
   endproperty
   property p_soft_start;
      wr_nc && bus_req.wdata[0] |-> ##2 mac_control.soft_reset_active;
   endproperty
   property p_soft_len;
      $fell(mac_control.soft_reset_active) |-> soft_cnt == SOFT_RESET_LEN;
   endproperty
   property p_soft_hold;
      !idle && $past(!idle) |-> mac_control[10:8] == 3'h0 && mac_control[6:0] == 7'h00
         && $stable(mac_control.wakeup_function_enable);
   endproperty
   property p_nc_write;
      wr_nc && !bus_req.wdata[0] |-> ##2 mac_control[11:8] ==
         $past({bus_req.wdata[6], bus_req.wdata[4], bus_req.wdata[2:1]}, 2);
   endproperty
   property p_tx_set;
      wr_tx |-> ##2 mac_control.transmit_request;
   endproperty
   property p_tx_clear;
      tx_complete && !wr_tx |-> ##2 !mac_control.transmit_request;
   endproperty
   property p_tc_read;
      $past(rd_tc) |-> !rdata[7] && rdata[6:0] == mac_control[6:0];
   endproperty
   // no read, or a read of an unmapped address, leaves the read data at zero
   property p_rdata_idle;
      !$past(rd_nc || rd_st || rd_tc) |-> rdata == 8'h00;
   endproperty
   // a done event in the very cycle of a status read must survive that read
   sequence s_set_race;
      rd_st && mac_status.index_two_tx_done && !mac_status.tx_busy_two;
   endsequence
   sequence s_race_quiet;
      !bus_req.rd && !bus_req.wr && !mac_status.tx_busy_two && idle;
   endsequence
   property p_set_wins;
      s_set_race ##1 s_race_quiet ##1 (rd_st && idle) |=> rdata[3];
   endproperty
   a_nc_read: assert property (p_nc_read) else $error("control read wrong");
   a_ns_read: assert property (p_ns_read) else $error("status read wrong");
   a_read_clears: assert property (p_read_clears) else $error("flag kept");
   a_soft_start: assert property (p_soft_start) else $error("no soft reset");
   a_soft_len: assert property (p_soft_len) else $error("soft reset length");
   a_soft_hold: assert property (p_soft_hold) else $error("soft hold");
   a_nc_write: assert property (p_nc_write) else $error("control out");
   a_tx_set: assert property (p_tx_set) else $error("tx request lost");
   a_tx_clear: assert property (p_tx_clear) else $error("tx not cleared");
   a_tc_read: assert property (p_tc_read) else $error("transmit read wrong");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
endmodule

/* File: network_tx_control_status_regs.sv */
// network control, network status and transmit control register bank
`timescale 1ns/1ps

// Behaviour
// R1: reserved bits written zero, read back zero
// R2: host waits 1ms after general purpose change
// R3: wakeup enable; clearing it clears wakeup status
// R4: soft reset keeps wakeup enable and status
// R5: forced collision test mode bit
// R6: duplex flag reports internal phy duplex
// R7: two-bit loopback path select field
// R8: soft reset bit self clears after 10us
// R9: speed bit, zero means 100Mbps
// R10: link bit reports phy link good
// R11: wakeup event flag, clear by read/write-one
// R12: index two done flag, clear read/write-one
// R13: index one done flag, clear read/write-one
// R14: receive fifo overflow read-only flag
// R15: jabber timer disable control bit
// R16: excess collision retry versus abort policy
// R17: per-index pad append disable bits
// R18: per-index fcs append disable bits
// R19: transmit request, self clears when sent
// R20: power-on versus software reset defaults
// R21: set wins over clear; zero writes ignored
module network_tx_control_status_regs #(
   parameter int SOFT_RESET_LEN = net_regs_pkg::SOFT_RESET_CYCLES
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire net_regs_pkg::reg_req_t     bus_req,
   output logic [net_regs_pkg::DATA_W-1:0] rdata,
   input  wire net_regs_pkg::mac_status_t  mac_status,
   input  wire logic                       tx_complete,
   output net_regs_pkg::mac_control_t      mac_control
);
   import net_regs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire logic sel_nc    = (bus_req.addr == OFF_NETWORK_CONTROL);
   wire logic sel_ns    = (bus_req.addr == OFF_NETWORK_STATUS);
   wire logic sel_tc    = (bus_req.addr == OFF_TRANSMIT_CONTROL);
   wire logic wr_nc     = bus_req.wr & sel_nc;
   wire logic wr_ns     = bus_req.wr & sel_ns;
   wire logic wr_tc     = bus_req.wr & sel_tc;
   wire logic rd_ns     = bus_req.rd & sel_ns;
   wire logic [7:0] wd  = bus_req.wdata;

   ////////////////////////////////////////////////////////////////////////////
   // software reset timer

   logic                  soft_rst;
   logic [SOFT_CNT_W-1:0] soft_cnt;

   // a write of one starts the reset; the bit clears itself when the count ends
   wire logic soft_start = wr_nc & wd[NC_SOFT_RESET]; // R8
   wire logic soft_last  = soft_rst & (soft_cnt == SOFT_CNT_W'(SOFT_RESET_LEN - 1)); // R8

   always_ff @(posedge core_clk) begin
      if (rst) begin
         soft_rst <= BIT_RESET; // R20
         soft_cnt <= '0;
      end else if (soft_start & ~soft_rst) begin
         soft_rst <= 1'b1; // R8
         soft_cnt <= '0;
      end else if (soft_last) begin
         soft_rst <= 1'b0; // R8
         soft_cnt <= '0;
      end else if (soft_rst) begin
         soft_cnt <= soft_cnt + SOFT_CNT_W'(1);
      end
   end

   // registers marked for both resets are held at default during soft reset
   wire logic any_rst = rst | soft_rst; // R20

   ////////////////////////////////////////////////////////////////////////////
   // network control

   logic      wake_en;
   logic      force_col;
   loopback_t loop_sel;

   // wakeup enable survives soft reset; of the two resets only power-on clears it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wake_en <= BIT_RESET; // R4
      end else if (wr_nc & ~soft_rst) begin
         wake_en <= wd[NC_WAKE_EN]; // R3
      end
   end

   always_ff @(posedge core_clk) begin
      if (any_rst) begin
         force_col <= BIT_RESET; // R20
         loop_sel  <= loopback_t'(LOOPBACK_RESET); // R20
      end else if (wr_nc) begin
         force_col <= wd[NC_FORCE_COL]; // R5
         loop_sel  <= loopback_t'(wd[NC_LOOP_HI:NC_LOOP_LO]); // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit control

   logic [6:1] tc_cfg;
   logic       tx_req;

   always_ff @(posedge core_clk) begin
      if (any_rst) begin
         tc_cfg <= '0; // R20
      end else if (wr_tc) begin
         tc_cfg <= wd[6:1]; // R15 R16 R17 R18
      end
   end

   // a new request outranks the completion of an earlier one
   wire logic next_tx_req = (wr_tc & wd[TC_TX_REQUEST]) | (tx_req & ~tx_complete); // R19

   always_ff @(posedge core_clk) begin
      if (any_rst) begin
         tx_req <= BIT_RESET;
      end else begin
         tx_req <= next_tx_req; // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status flags

   logic wake_flag;
   logic two_done;
   logic one_done;

   // clearing wakeup enable wipes the stored wakeup event
   wire logic wake_wipe = rst | (wr_nc & ~soft_rst & ~wd[NC_WAKE_EN]); // R3 R4
   wire logic wake_clr  = rd_ns | (wr_ns & wd[NS_WAKE_EVENT]); // R11 R21
   wire logic two_clr   = rd_ns | (wr_ns & wd[NS_TWO_DONE]); // R12
   wire logic one_clr   = rd_ns | (wr_ns & wd[NS_ONE_DONE]); // R13
   // a pending transmission holds its done flag low
   wire logic two_wipe  = any_rst | mac_status.tx_busy_two; // R12
   wire logic one_wipe  = any_rst | mac_status.tx_busy_one; // R13

   sticky_flag u_wake (
      .core_clk  (core_clk),
      .clear_all (wake_wipe),
      .set_event (mac_status.wakeup_event & wake_en),
      .clear_req (wake_clr),
      .flag      (wake_flag)
   );

   sticky_flag u_two (
      .core_clk  (core_clk),
      .clear_all (two_wipe),
      .set_event (mac_status.index_two_tx_done),
      .clear_req (two_clr),
      .flag      (two_done)
   );

   sticky_flag u_one (
      .core_clk  (core_clk),
      .clear_all (one_wipe),
      .set_event (mac_status.index_one_tx_done),
      .clear_req (one_clr),
      .flag      (one_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read-back

   logic [7:0] nc_view;
   logic [7:0] ns_view;
   logic [7:0] tc_view;
   logic [7:0] rd_mux;

   // reserved positions read zero; the host writes zero there
   always_comb begin
      nc_view                          = RESERVED_READ; // R1
      nc_view[NC_WAKE_EN]              = wake_en;
      nc_view[NC_FORCE_COL]            = force_col;
      nc_view[NC_DUPLEX]               = mac_status.phy_duplex_flag; // R6
      nc_view[NC_LOOP_HI:NC_LOOP_LO]   = loop_sel;
      nc_view[NC_SOFT_RESET]           = soft_rst;
   end

   // speed is only meaningful while link is good; passed through as is
   always_comb begin
      ns_view                 = RESERVED_READ; // R1
      ns_view[NS_SPEED]       = mac_status.phy_speed_10; // R9
      ns_view[NS_LINK]        = mac_status.phy_link_good; // R10
      ns_view[NS_WAKE_EVENT]  = wake_flag; // R11
      ns_view[NS_TWO_DONE]    = two_done; // R12
      ns_view[NS_ONE_DONE]    = one_done; // R13
      ns_view[NS_RX_OVERFLOW] = mac_status.receive_fifo_overflow; // R14
   end

   always_comb begin
      tc_view                = RESERVED_READ; // R1
      tc_view[6:1]           = tc_cfg;
      tc_view[TC_TX_REQUEST] = tx_req; // R19
   end

   // unmapped addresses read zero
   assign rd_mux = sel_nc ? nc_view :
                   sel_ns ? ns_view :
                   sel_tc ? tc_view : RESERVED_READ;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (bus_req.rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control outputs, registered

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mac_control <= '0;
      end else begin
         mac_control.wakeup_function_enable <= wake_en; // R3
         mac_control.forced_collision_test  <= force_col; // R5
         mac_control.loopback_select        <= loop_sel; // R7
         mac_control.soft_reset_active      <= soft_rst; // R8
         mac_control.jabber_timer_disable   <= tc_cfg[TC_JABBER_OFF]; // R15
         mac_control.excess_collision_retry <= tc_cfg[TC_EXCESS_RETRY]; // R16
         mac_control.index_two_pad_off      <= tc_cfg[TC_TWO_PAD_OFF]; // R17
         mac_control.index_two_fcs_off      <= tc_cfg[TC_TWO_FCS_OFF]; // R18
         mac_control.index_one_pad_off      <= tc_cfg[TC_ONE_PAD_OFF]; // R17
         mac_control.index_one_fcs_off      <= tc_cfg[TC_ONE_FCS_OFF]; // R18
         mac_control.transmit_request       <= tx_req; // R19
      end
   end

   // the 1ms quiet time after a general purpose change is the host's to keep;
   // that register lives elsewhere and nothing here enforces it (R2)
endmodule

/* File: sticky_flag.sv */
// one status bit: set by an event, cleared by read or by write of one
`timescale 1ns/1ps
module sticky_flag (
   input  wire logic core_clk,
   input  wire logic clear_all,
   input  wire logic set_event,
   input  wire logic clear_req,
   output logic      flag
);
   import net_regs_pkg::*;

   // the event wins over a clear in the same cycle
   wire logic next_flag = set_event | (flag & ~clear_req); // R21

   always_ff @(posedge core_clk) begin
      if (clear_all) begin
         flag <= BIT_RESET;
      end else begin
         flag <= next_flag;
      end
   end
endmodule

/* File: test_network_tx_control_status_regs.sv */
// testbench: register bank driven through its host port
`timescale 1ns/1ps
module test_network_tx_control_status_regs;
   import net_regs_pkg::*;
   logic         core_clk;
   logic         rst;
   reg_req_t     bus_req;
   logic [7:0]   rdata;
   mac_status_t  mac_status;
   logic         tx_complete;
   mac_control_t mac_control;
   logic [7:0]   q;
   logic [7:0]   d;
   int           failures;
   int           compares;
   network_tx_control_status_regs #(.SOFT_RESET_LEN(8)) dut_u (
      .core_clk    (core_clk),
      .rst         (rst),
      .bus_req     (bus_req),
      .rdata       (rdata),
      .mac_status  (mac_status),
      .tx_complete (tx_complete),
      .mac_control (mac_control)
   );
   mac_side_model #(.DELAY(6)) mac_u (
      .core_clk    (core_clk),
      .rst         (rst),
      .mac_control (mac_control),
      .tx_complete (tx_complete)
   );
   ////////////////////////////////////////
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk) bus_req <= '{a, v, w, !w};
      @(posedge core_clk) bus_req <= '0;
      #1 q = rdata;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(nm, q, exp);
   endtask
   task automatic pulse(input logic [2:0] e);
      @(posedge core_clk) mac_status[4:2] <= e;
      @(posedge core_clk) mac_status[4:2] <= 3'h0;
   endtask
   // status read and new events in one cycle: the events must outlive the read
   task automatic race(input logic [2:0] e);
      @(posedge core_clk) begin
         bus_req         <= '{OFF_NETWORK_STATUS, 8'h00, 1'b0, 1'b1};
         mac_status[4:2] <= e;
      end
      @(posedge core_clk) begin
         bus_req         <= '0;
         mac_status[4:2] <= 3'h0;
      end
      #1 q = rdata;
   endtask
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // nearly ten thousand cycles of margin over the real run
   initial begin
      #100000;
      failures++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      bus_req = '0;
      mac_status = '0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      // no access here changes the general purpose register, so no quiet time is owed
      acc(1'b1, 8'h03, 8'hFF);
      for (int i = 0; i < 4; i++) rchk("reset", 8'(i), 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk) mac_status.phy_duplex_flag <= i[0];
         d = 8'(64 + i * 2 + (i % 2) * 16);
         acc(1'b1, 8'h00, d);
         rchk("control", 8'h00, d | 8'((i % 2) * 8));
         chk("loop_out", 8'(mac_control.loopback_select), 8'(i));
      end
      $display("test control done");
      for (int j = 0; j < 8; j++) begin
         @(posedge core_clk) mac_status[8:5] <= {j[2], j[1], 1'b0, j[0]};
         rchk("status", 8'h01, {j[2], j[1], 4'h0, j[0], 1'b0});
      end
      @(posedge core_clk) mac_status <= '0;
      $display("test status done");
      pulse(3'h7);
      rchk("events", 8'h01, 8'h2C);
      rchk("read_clear", 8'h01, 8'h00);
      pulse(3'h7);
      acc(1'b1, 8'h01, 8'h00);
      acc(1'b1, 8'h01, 8'h04);
      rchk("w1c", 8'h01, 8'h28);
      @(posedge core_clk) mac_status.tx_busy_two <= 1'b1;
      pulse(3'h1);
      rchk("pending", 8'h01, 8'h00);
      @(posedge core_clk) mac_status.tx_busy_two <= 1'b0;
      pulse(3'h4);
      acc(1'b1, 8'h00, 8'h16);
      pulse(3'h4);
      rchk("wake_off", 8'h01, 8'h00);
      race(3'h7);
      chk("race_read", q, 8'h00);
      rchk("set_wins", 8'h01, 8'h0C);
      @(posedge core_clk) mac_status.tx_busy_one <= 1'b1;
      pulse(3'h2);
      rchk("pending_one", 8'h01, 8'h00);
      @(posedge core_clk) mac_status.tx_busy_one <= 1'b0;
      $display("test flags done");
      acc(1'b1, 8'h02, 8'h7F);
      rchk("tx_busy", 8'h02, 8'h7F);
      chk("tc_out", {1'b0, mac_control[6:1], 1'b0}, 8'h7E);
      repeat (8) @(posedge core_clk);
      rchk("tx_done", 8'h02, 8'h7E);
      acc(1'b1, 8'h02, 8'h2A);
      rchk("tc_a", 8'h02, 8'h2A);
      acc(1'b1, 8'h02, 8'h54);
      rchk("tc_b", 8'h02, 8'h54);
      $display("test transmit done");
      acc(1'b1, 8'h00, 8'h56);
      pulse(3'h4);
      acc(1'b1, 8'h00, 8'h41);
      @(posedge core_clk);
      rchk("soft_nc", 8'h00, 8'h41);
      rchk("soft_tc", 8'h02, 8'h00);
      acc(1'b1, 8'h02, 8'h7E);
      rchk("soft_ns", 8'h01, 8'h20);
      repeat (4) @(posedge core_clk);
      rchk("soft_end", 8'h00, 8'h40);
      rchk("soft_ign", 8'h02, 8'h00);
      @(posedge core_clk) rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rchk("por", 8'h00, 8'h00);
      $display("test soft reset done");
      conclude();
   end
endmodule
bind network_tx_control_status_regs net_regs_props #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) props_u (
   .core_clk    (core_clk),
   .rst         (rst),
   .bus_req     (bus_req),
   .rdata       (rdata),
   .mac_status  (mac_status),
   .tx_complete (tx_complete),
   .mac_control (mac_control)
);
